// ==== verilog/ppmc_defines.vh ====
`ifndef PPMC_DEFINES_VH
`define PPMC_DEFINES_VH

// Register address on the internal register bus
`define PPMC_ADDR_CONFIG   8'h9f
`define PPMC_RESET_VALUE   8'h00

// Field positions within the configuration register
`define PPMC_MODE_HI       7
`define PPMC_MODE_LO       5
`define PPMC_INMODE_HI     6
`define PPMC_DIR_BIT       4
`define PPMC_LATCH_BIT     3
`define PPMC_PIN_HI        2
`define PPMC_PIN_LO        0
`define PPMC_PIN_RESET     3'h0

// Output mode codes
`define PPMC_OUT_NORMAL    3'h0
`define PPMC_OUT_HIGH      3'h3

// Input mode codes
`define PPMC_IN_NOPULL     2'h0
`define PPMC_IN_PULLDOWN   2'h1
`define PPMC_IN_PULLUP     2'h2
`define PPMC_IN_OFF        2'h3

// Direction select values
`define PPMC_DIR_OUT       1'b0
`define PPMC_DIR_IN        1'b1

`endif

// ==== verilog/ppmc_port_pin_mode_config.v ====
// Function
// - A non-latching write loads the mode field into the indexed pin, input or output side.
// - Input mode bits decode as no pull, pull-down, pull-up, or buffer disabled.
// - A read returns the mode of the stored pin and stored direction in bits 7:5.
// - The direction bit is write-only; zero selects output, one selects input configuration.
// - A latching write stores pin index and direction and changes no pin mode.
// - Stored index and direction persist until the next latching write.
// - A non-latching write changes only the addressed pin; the other seven stay.
// - The three-bit pin index selects the pin by its binary value.
`timescale 1ns/1ps
`include "ppmc_defines.vh"

module ppmc_port_pin_mode_config #(
    parameter PINS   = 8,
    parameter AW     = 8
) (
    // Clock and reset
    input  wire                  i_clk,
    input  wire                  i_nrst,
    // Register port
    input  wire [AW-1:0]         i_addr,
    input  wire [7:0]            i_wdata,
    input  wire                  i_wr,
    input  wire                  i_rd,
    output reg  [7:0]            o_rdata,
    // Pad controls per pin
    output wire [PINS-1:0]       o_out_high_drive,
    output wire [PINS-1:0]       o_in_buf_en,
    output wire [PINS-1:0]       o_in_pull_down,
    output wire [PINS-1:0]       o_in_pull_up
);

    // Bus decode
    wire                sel;
    wire                wr_hit;
    wire                rd_hit;
    wire                latch;
    wire                dir;
    wire [2:0]          pin;
    wire [2:0]          mode;
    wire [1:0]          in_mode;

    // Flattened per-pin modes, so each pin's flops have a single driver
    wire [3*PINS-1:0]   out_mode_all;
    wire [2*PINS-1:0]   in_mode_all;

    // Readback pointer
    reg  [2:0]          rb_pin_q;
    reg  [2:0]          rb_pin_d;
    reg                 rb_dir_q;
    reg                 rb_dir_d;

    // Read data path
    reg  [2:0]          rd_mode;
    reg  [7:0]          rdata_d;

    assign sel     = (i_addr == `PPMC_ADDR_CONFIG);
    assign wr_hit  = i_wr & sel;
    assign rd_hit  = i_rd & sel;
    assign latch   = i_wdata[`PPMC_LATCH_BIT];
    assign dir     = i_wdata[`PPMC_DIR_BIT];
    assign mode    = i_wdata[`PPMC_MODE_HI:`PPMC_MODE_LO];
    assign in_mode = i_wdata[`PPMC_INMODE_HI:`PPMC_MODE_LO];
    assign pin     = i_wdata[`PPMC_PIN_HI:`PPMC_PIN_LO];

    // only a latching write moves the pointer
    always @* begin
        rb_pin_d = rb_pin_q;
        rb_dir_d = rb_dir_q;
        if (wr_hit && latch) begin
            rb_pin_d = pin;
            rb_dir_d = dir;
        end
    end

    // pointer resets to pin zero output
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rb_pin_q <= `PPMC_PIN_RESET;
            rb_dir_q <= `PPMC_DIR_OUT;
        end else begin
            rb_pin_q <= rb_pin_d;
            rb_dir_q <= rb_dir_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : g_pin
            localparam [2:0] PIN_ID = g;

            wire       hit;
            reg  [2:0] out_mode_q;
            reg  [2:0] out_mode_d;
            reg  [1:0] in_mode_q;
            reg  [1:0] in_mode_d;
            reg        high_drive_q;
            reg        high_drive_d;
            reg        buf_en_q;
            reg        buf_en_d;
            reg        pull_down_q;
            reg        pull_down_d;
            reg        pull_up_q;
            reg        pull_up_d;

            // only the addressed pin sees the write
            assign hit = wr_hit && !latch && (pin == PIN_ID);

            // direction bit picks the input or output side
            always @* begin
                out_mode_d = out_mode_q;
                in_mode_d  = in_mode_q;
                if (hit) begin
                    if (dir == `PPMC_DIR_IN) begin
                        in_mode_d = in_mode;
                    end else begin
                        // Illegal codes stored as written; software keeps to two
                        out_mode_d = mode;
                    end
                end
            end

            always @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    out_mode_q <= `PPMC_OUT_NORMAL;
                    in_mode_q  <= `PPMC_IN_NOPULL;
                end else begin
                    out_mode_q <= out_mode_d;
                    in_mode_q  <= in_mode_d;
                end
            end

            // Only 011 gives high drive; illegal codes leave normal drive
            always @* begin
                high_drive_d = 1'b0;
                if (out_mode_q == `PPMC_OUT_HIGH) begin
                    high_drive_d = 1'b1;
                end
            end

            always @* begin
                buf_en_d    = 1'b1;
                pull_down_d = 1'b0;
                pull_up_d   = 1'b0;
                case (in_mode_q)
                    `PPMC_IN_NOPULL: begin
                        buf_en_d    = 1'b1;
                        pull_down_d = 1'b0;
                        pull_up_d   = 1'b0;
                    end
                    `PPMC_IN_PULLDOWN: begin
                        buf_en_d    = 1'b1;
                        pull_down_d = 1'b1;
                        pull_up_d   = 1'b0;
                    end
                    `PPMC_IN_PULLUP: begin
                        buf_en_d    = 1'b1;
                        pull_down_d = 1'b0;
                        pull_up_d   = 1'b1;
                    end
                    default: begin
                        buf_en_d    = 1'b0;
                        pull_down_d = 1'b0;
                        pull_up_d   = 1'b0;
                    end
                endcase
            end

            // Registered so the pad controls come straight from flops
            always @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    high_drive_q <= 1'b0;
                    buf_en_q     <= 1'b1;
                    pull_down_q  <= 1'b0;
                    pull_up_q    <= 1'b0;
                end else begin
                    high_drive_q <= high_drive_d;
                    buf_en_q     <= buf_en_d;
                    pull_down_q  <= pull_down_d;
                    pull_up_q    <= pull_up_d;
                end
            end

            assign o_out_high_drive[g]    = high_drive_q;
            assign o_in_buf_en[g]         = buf_en_q;
            assign o_in_pull_down[g]      = pull_down_q;
            assign o_in_pull_up[g]        = pull_up_q;
            assign out_mode_all[3*g +: 3] = out_mode_q;
            assign in_mode_all[2*g +: 2]  = in_mode_q;
        end
    endgenerate

    // mode of stored pin and direction
    always @* begin
        if (rb_dir_q == `PPMC_DIR_IN) begin
            rd_mode = {1'b0, in_mode_all[2*rb_pin_q +: 2]};
        end else begin
            rd_mode = out_mode_all[3*rb_pin_q +: 3];
        end
    end

    // write-only bits and unmapped addresses read zero
    always @* begin
        rdata_d = `PPMC_RESET_VALUE;
        if (rd_hit) begin
            rdata_d = {rd_mode, 5'h00};
        end
    end

    // Read data stands for one cycle only
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= `PPMC_RESET_VALUE;
        end else begin
            o_rdata <= rdata_d;
        end
    end

endmodule

// ==== dv/ppmc_chk.sv ====
`timescale 1ns/1ps
module ppmc_chk(
    input wire i_clk, i_nrst, i_wr, i_rd,
    input wire [7:0] i_addr, i_wdata, o_rdata, o_out_high_drive, o_in_buf_en,
    input wire [7:0] o_in_pull_down, o_in_pull_up);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    reg [7:0] d1_q, d2_q;
    wire w = i_wr && i_addr == 8'h9f && !i_wdata[3];
    wire r = i_rd && i_addr == 8'h9f;
    wire [2:0] p = d2_q[2:0];
    wire [31:0] pd = {o_out_high_drive, o_in_buf_en, o_in_pull_down, o_in_pull_up};
    // Pads lag the write by two edges
    always @(posedge i_clk) {d2_q, d1_q} <= {d1_q, i_wdata};
    a_rd_idle: assert property (!$past(r) |-> o_rdata == 8'h00) else $error("stray rdata");
    a_pad_hold: assert property (!w |-> ##2 $stable(pd)) else $error("pad moved");
    a_rd_low_zero: assert property ($past(r) |-> o_rdata[4:0] == 5'h00) else $error("low bits");
    a_one_pin:
    assert property (w |-> ##2 ((pd ^ $past(pd)) & ~{4{8'h01 << p}}) == 32'h0) else $error("pin");
    a_drive_out:
    assert property (w && !i_wdata[4] |-> ##2 o_out_high_drive[p] == (d2_q[7:5] == 3'h3))
        else $error("drive");
    a_in_decode:
    assert property (w && i_wdata[4] |-> ##2 {o_in_pull_up[p], o_in_pull_down[p], o_in_buf_en[p]}
        == {d2_q[6:5] == 2'h2, d2_q[6:5] == 2'h1, d2_q[6:5] != 2'h3}) else $error("input mode");
    c_latch: cover property (i_wr && i_wdata[3]);
    c_write: cover property (w);
    c_read: cover property (r);
endmodule
bind ppmc_port_pin_mode_config ppmc_chk u_chk(.*);

// ==== dv/ppmc_sw_model.sv ====
`timescale 1ns/1ps
module ppmc_sw_model(
    input wire i_clk,
    input wire [7:0] i_rdata,
    output logic [7:0] o_addr = 8'h00, o_wdata = 8'h00,
    output logic o_wr = 1'b0, o_rd = 1'b0);
    task wr(input logic [7:0] ad, dt);
        {o_addr, o_wdata, o_wr} <= {ad, dt, 1'b1};
        @(posedge i_clk) {o_wdata, o_wr} <= {~dt, 1'b0};
        @(posedge i_clk);
    endtask
    task rd(input logic [7:0] ad, output logic [7:0] q);
        {o_addr, o_rd} <= {ad, 1'b1};
        @(posedge i_clk) o_rd <= 1'b0;
        @(posedge i_clk) q = i_rdata;
    endtask
endmodule

// ==== dv/ppmc_port_pin_mode_config_bench.sv ====
`timescale 1ns/1ps
module ppmc_port_pin_mode_config_bench;
    logic i_clk = 0, i_nrst = 0, w, r;
    logic [7:0] a, d, q, rdata, hd, be, pdn, pu;
    logic [31:0] s = 56, x, ex;
    int om[8], im[8], ptr, dir, err_total, compares, cyc;
    ppmc_sw_model u_sw(.i_clk(i_clk), .i_rdata(rdata), .o_addr(a), .o_wdata(d), .o_wr(w), .o_rd(r));
    ppmc_port_pin_mode_config u_dut(.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(a), .i_wdata(d),
        .i_wr(w), .i_rd(r), .o_rdata(rdata), .o_out_high_drive(hd), .o_in_buf_en(be),
        .o_in_pull_down(pdn), .o_in_pull_up(pu));
    function logic [31:0] xs();
        s ^= s << 13; s ^= s >> 17; s ^= s << 5;
        return s;
    endfunction
    task chk(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
    endtask
    task results();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial forever #25 i_clk = ~i_clk;
    always @(posedge i_clk) if (++cyc > 3000) begin err_total++; results(); end
    initial begin
        repeat (8) @(posedge i_clk);
        i_nrst <= 1;
        for (int n = 0; n < 400; n++) begin
            x = xs();
            // Unmapped address now and then, first read before any write
            ex[7:0] = (n && x[10:8] == 0) ? 8'h9e : 8'h9f;
            // output side: only the two legal mode codes, 000 and 011, are written
            if (!x[4]) x[7:5] = {1'b0, x[5], x[5]};
            if (n) u_sw.wr(ex[7:0], x[7:0]);
            if (n && ex[7:0] == 8'h9f && x[3]) {ptr, dir} = {29'h0, x[2:0], 31'h0, x[4]};
            else if (n && ex[7:0] == 8'h9f) if (x[4]) im[x[2:0]] = x[6:5]; else om[x[2:0]] = x[7:5];
            u_sw.rd(ex[7:0], q);
            chk(q, ex[7:0] != 8'h9f ? 0 : (dir ? im[ptr] : om[ptr]) << 5);
            for (int i = 0; i < 8; i++)
                {ex[24+i], ex[16+i], ex[8+i], ex[i]} = {om[i] == 3, im[i] != 3, im[i] == 1, im[i] == 2};
            chk({hd, be, pdn, pu}, ex);
        end
        $display("random test done");
        results();
    end
endmodule
